// ### include/sdb_pkg.sv
package sdb_pkg;

  // array organisation
  localparam int unsigned BANKS        = 4;
  localparam int unsigned ROWS         = 4096;
  localparam int unsigned COLS_WIDE    = 512;
  localparam int unsigned COLS_NARROW  = 1024;
  localparam int unsigned MEM_WORDS    = BANKS * ROWS * COLS_WIDE;
  localparam int unsigned MEM_AW       = 23;
  localparam int unsigned ROW_W        = 12;
  localparam int unsigned COL_W        = 10;
  localparam int unsigned DQ_W         = 16;
  localparam logic [9:0]  PAGE_WIDE    = 10'h1ff;
  localparam logic [9:0]  PAGE_NARROW  = 10'h3ff;

  // command codes as {ras_n, cas_n, we_n}
  localparam logic [2:0] CMD_LMR    = 3'h0;
  localparam logic [2:0] CMD_REF    = 3'h1;
  localparam logic [2:0] CMD_PRE    = 3'h2;
  localparam logic [2:0] CMD_ACT    = 3'h3;
  localparam logic [2:0] CMD_WRITE  = 3'h4;
  localparam logic [2:0] CMD_READ   = 3'h5;
  localparam logic [2:0] CMD_BST    = 3'h6;
  localparam logic [2:0] CMD_NOP    = 3'h7;

  // operating_mode_config layout
  localparam int unsigned MR_W          = 12;
  localparam int unsigned MR_BL_LSB     = 0;
  localparam int unsigned MR_ORDER_BIT  = 3;
  localparam int unsigned MR_LAT_LSB    = 4;
  localparam int unsigned MR_OPM_LSB    = 7;
  localparam int unsigned MR_WBM_BIT    = 9;
  localparam logic [11:0] MR_RESET      = 12'h000;

  // burst length codes
  localparam logic [2:0] BL_1    = 3'h0;
  localparam logic [2:0] BL_2    = 3'h1;
  localparam logic [2:0] BL_4    = 3'h2;
  localparam logic [2:0] BL_8    = 3'h3;
  localparam logic [2:0] BL_PAGE = 3'h7;

  // read latency codes
  localparam logic [2:0] LAT_2 = 3'h2;
  localparam logic [2:0] LAT_3 = 3'h3;

  // write buffer
  localparam int unsigned WB_DEPTH = 2;

  typedef enum logic [2:0] {
    SDB_IDLE = 3'b001,
    SDB_RD   = 3'b010,
    SDB_WR   = 3'b100
  } sdb_burst_t;

  typedef struct packed {
    logic [MEM_AW-1:0] idx;
    logic [DQ_W-1:0]   data;
    logic [1:0]        lane_en;
  } sdb_wentry_t;

endpackage

// ### rtl/sdb_core.sv
`timescale 1ns/10ps

module sdb_core #(
  parameter logic NARROW = 1'b0
) (
  input  wire logic        clk_in,
  input  wire logic        rst_n_in,
  input  wire logic        cke_in,
  input  wire logic        cs_n_in,
  input  wire logic        ras_n_in,
  input  wire logic        cas_n_in,
  input  wire logic        we_n_in,
  input  wire logic        bank_select_lo_in,
  input  wire logic        bank_select_hi_in,
  input  wire logic [11:0] addr_in,
  input  wire logic [1:0]  dqm_in,
  input  wire logic [15:0] dq_in,
  output logic      [15:0] dq_out,
  output logic      [1:0]  dq_oe_out
);

  typedef struct packed {
    logic [sdb_pkg::MR_W-1:0]                  mode;
    sdb_pkg::sdb_burst_t                       burst;
    logic [1:0]                                bank;
    logic [sdb_pkg::COL_W-1:0]                 start;
    logic [sdb_pkg::COL_W-1:0]                 cnt;
    logic [3:0][sdb_pkg::ROW_W-1:0]            rows;
    logic [3:0]                                row_open;
    logic [15:0]                               dly_data;
    logic                                      dly_v;
    logic [1:0]                                dqm_d1;
    logic [15:0]                               dout;
    logic [1:0]                                oe;
    logic [sdb_pkg::WB_DEPTH-1:0][40:0]        wbuf;
    logic                                      wp;
    logic                                      rp;
    logic [1:0]                                wcnt;
  } sdb_state_t;

  sdb_state_t q;
  sdb_state_t d;

  logic [15:0] mem_q [0:sdb_pkg::MEM_WORDS-1];

  // mask of the column bits that move inside a fixed burst
  function automatic logic [9:0] sdb_blk_mask(input logic [2:0] bl);
    unique case (bl)
      sdb_pkg::BL_2:    sdb_blk_mask = 10'h001;
      sdb_pkg::BL_4:    sdb_blk_mask = 10'h003;
      sdb_pkg::BL_8:    sdb_blk_mask = 10'h007;
      default:          sdb_blk_mask = 10'h000;
    endcase
  endfunction

  function automatic logic sdb_is_page(input logic [2:0] bl);
    sdb_is_page = (bl == sdb_pkg::BL_PAGE);
  endfunction

  function automatic logic [9:0] sdb_col(input logic [9:0] start,
                                         input logic [9:0] k,
                                         input logic [2:0] bl,
                                         input logic       ilv);
    logic [9:0] page;
    logic [9:0] msk;
    logic [9:0] ofs;
    page = NARROW ? sdb_pkg::PAGE_NARROW : sdb_pkg::PAGE_WIDE;
    msk  = sdb_blk_mask(bl);
    // interleave is not offered with full page, so the page case ignores ilv
    ofs  = ilv ? (start ^ k) : 10'(start + k);
    if (sdb_is_page(bl))
      sdb_col = 10'(start + k) & page;
    else
      sdb_col = (start & ~msk) | (ofs & msk);
  endfunction

  function automatic logic [22:0] sdb_idx(input logic [1:0]  bank,
                                          input logic [11:0] row,
                                          input logic [9:0]  col);
    // narrow parts pack two byte columns into one word of the array
    sdb_idx = NARROW ? {bank, row, col[9:1]} : {bank, row, col[8:0]};
  endfunction

  logic [2:0]  cmd;
  logic        cmd_ok;
  logic [2:0]  bl;
  logic        ilv;
  logic        lat3;
  logic        wbm_single;
  logic [1:0]  cmd_bank;
  logic [9:0]  cmd_col;
  logic [9:0]  cur_col;
  logic [9:0]  last_cnt;
  logic        rd_now;
  logic [15:0] rd_word;
  logic        wb_push;
  logic        wb_full;
  logic        wb_pop;
  logic        drain_rdy;
  sdb_pkg::sdb_wentry_t wb_in;
  sdb_pkg::sdb_wentry_t wb_head;

  always_comb
  begin
    cmd        = {ras_n_in, cas_n_in, we_n_in};
    cmd_ok     = !cs_n_in && cke_in && (cmd != sdb_pkg::CMD_NOP);
    bl         = q.mode[sdb_pkg::MR_BL_LSB +: 3];
    ilv        = q.mode[sdb_pkg::MR_ORDER_BIT] && !sdb_is_page(bl);
    lat3       = (q.mode[sdb_pkg::MR_LAT_LSB +: 3] == sdb_pkg::LAT_3);
    wbm_single = q.mode[sdb_pkg::MR_WBM_BIT];
    cmd_bank   = {bank_select_hi_in, bank_select_lo_in};
    cmd_col    = NARROW ? addr_in[9:0] : {1'b0, addr_in[8:0]};
    last_cnt   = sdb_blk_mask(bl);
    cur_col    = sdb_col(q.start, q.cnt, bl, ilv);
    rd_now     = (q.burst == sdb_pkg::SDB_RD);
    rd_word    = mem_q[sdb_idx(q.bank, q.rows[q.bank], cur_col)];
    if (NARROW)
      rd_word = {8'h00, cur_col[0] ? rd_word[15:8] : rd_word[7:0]};
  end

  // write word for the current column, taken from the pins this edge
  function automatic sdb_pkg::sdb_wentry_t sdb_wword(input logic [1:0]  bank,
                                                     input logic [11:0] row,
                                                     input logic [9:0]  col,
                                                     input logic [15:0] data,
                                                     input logic [1:0]  dqm);
    sdb_pkg::sdb_wentry_t e;
    e.idx = sdb_idx(bank, row, col);
    if (NARROW)
    begin
      e.data    = {data[7:0], data[7:0]};
      e.lane_en = {col[0], !col[0]} & {2{!dqm[0]}};
    end
    else
    begin
      e.data    = data;
      e.lane_en = ~dqm;
    end
    sdb_wword = e;
  endfunction

  always_comb
  begin
    d         = q;
    wb_push   = 1'b0;
    wb_in     = '0;
    // the array has one port, so a read burst holds off the write drain
    drain_rdy = !rd_now;
    wb_head   = sdb_pkg::sdb_wentry_t'(q.wbuf[q.rp]);
    wb_pop    = (q.wcnt != 2'h0) && drain_rdy;
    wb_full   = (q.wcnt == 2'(sdb_pkg::WB_DEPTH));
    d.dqm_d1  = dqm_in;

    // burst progress for the edge just taken
    unique case (q.burst)
      sdb_pkg::SDB_RD:
      begin
        d.cnt = 10'(q.cnt + 10'h001);
        if (!sdb_is_page(bl) && q.cnt == last_cnt)
          d.burst = sdb_pkg::SDB_IDLE;
      end
      sdb_pkg::SDB_WR:
      begin
        wb_in   = sdb_wword(q.bank, q.rows[q.bank], cur_col, dq_in, dqm_in);
        wb_push = 1'b1;
        d.cnt   = 10'(q.cnt + 10'h001);
        if (!sdb_is_page(bl) && q.cnt == last_cnt)
          d.burst = sdb_pkg::SDB_IDLE;
      end
      sdb_pkg::SDB_IDLE:
      begin
        d.cnt = q.cnt;
      end
    endcase

    // read output pipeline: word at edge n+m-1, dqm two clocks ahead
    d.dly_data = rd_word;
    d.dly_v    = rd_now;
    if (lat3)
    begin
      d.dout = q.dly_data;
      d.oe   = {2{q.dly_v}} & ~q.dqm_d1;
    end
    else
    begin
      d.dout = rd_word;
      d.oe   = {2{rd_now}} & ~q.dqm_d1;
    end

    if (cmd_ok)
    begin
      unique case (cmd)
        sdb_pkg::CMD_LMR:
          d.mode = addr_in;
        sdb_pkg::CMD_ACT:
        begin
          d.rows[cmd_bank]     = addr_in;
          d.row_open[cmd_bank] = 1'b1;
        end
        sdb_pkg::CMD_READ:
        begin
          d.bank  = cmd_bank;
          d.start = cmd_col;
          d.cnt   = 10'h000;
          d.burst = sdb_pkg::SDB_RD;
        end
        sdb_pkg::CMD_WRITE:
        begin
          // first word rides with the command itself
          d.bank  = cmd_bank;
          d.start = cmd_col;
          d.cnt   = 10'h001;
          wb_in   = sdb_wword(cmd_bank, q.rows[cmd_bank], cmd_col, dq_in, dqm_in);
          wb_push = 1'b1;
          if (wbm_single || (!sdb_is_page(bl) && last_cnt == 10'h000))
            d.burst = sdb_pkg::SDB_IDLE;
          else
            d.burst = sdb_pkg::SDB_WR;
        end
        sdb_pkg::CMD_BST:
          d.burst = sdb_pkg::SDB_IDLE;
        sdb_pkg::CMD_PRE:
        begin
          d.burst = sdb_pkg::SDB_IDLE;
          if (addr_in[10])
            d.row_open = 4'h0;
          else
            d.row_open[cmd_bank] = 1'b0;
        end
        default:
          d.burst = d.burst;
      endcase
    end

    // two-entry write buffer; a full buffer refuses the word unless its head drains on the same edge
    if (wb_push && wb_full && !wb_pop)
      wb_push = 1'b0;
    if (wb_push)
    begin
      d.wbuf[q.wp] = wb_in;
      d.wp         = !q.wp;
    end
    if (wb_pop)
      d.rp = !q.rp;
    d.wcnt = 2'(q.wcnt + {1'b0, wb_push} - {1'b0, wb_pop});
  end

  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      q       <= '0;
      q.mode  <= sdb_pkg::MR_RESET;
      q.burst <= sdb_pkg::SDB_IDLE;
    end
    else
    begin
      q <= d;
    end
  end

  // array keeps no reset; contents are undefined until written
  always_ff @(posedge clk_in)
  begin
    if (wb_pop)
    begin
      for (int i = 0; i < 2; i++)
      begin
        if (wb_head.lane_en[i])
          mem_q[wb_head.idx][i*8 +: 8] <= wb_head.data[i*8 +: 8];
      end
    end
  end

  assign dq_out    = q.dout;
  assign dq_oe_out = q.oe;

endmodule

// ### tb/sdb_core_properties.sv
`timescale 1ns/10ps
module sdb_core_chk (
  input wire logic        clk_in,
  input wire logic        rst_n_in,
  input wire logic        cke_in,
  input wire logic        cs_n_in,
  input wire logic        ras_n_in,
  input wire logic        cas_n_in,
  input wire logic        we_n_in,
  input wire logic [11:0] addr_in,
  input wire logic [1:0]  dqm_in,
  input wire logic [1:0]  dq_oe_out
);
  logic       tk;
  logic       rd;
  logic       cut;
  logic [2:0] cmd;
  logic [2:0] bl_q;
  logic       l3_q;
  assign cmd = {ras_n_in, cas_n_in, we_n_in};
  assign tk  = !cs_n_in && cke_in;
  assign rd  = tk && cmd == sdb_pkg::CMD_READ;
  // any of these ends a running burst, so length checks need them absent
  assign cut = rd || (tk && cmd inside {sdb_pkg::CMD_WRITE, sdb_pkg::CMD_BST, sdb_pkg::CMD_PRE});
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      bl_q <= 3'h0;
      l3_q <= 1'b0;
    end
    else if (tk && cmd == sdb_pkg::CMD_LMR)
    begin
      bl_q <= addr_in[2:0];
      l3_q <= addr_in[6:4] == sdb_pkg::LAT_3;
    end
  end
  default clocking @(posedge clk_in);
  endclocking
  default disable iff (!rst_n_in);
  reset_quiet_a: assert property (
    $rose(rst_n_in) |-> dq_oe_out == 2'b00) else $error("drive right after reset");
  oe_cause_a: assert property (
    $rose(|dq_oe_out) |-> $past(rd, 2) || $past(rd, 3)) else $error("drive without read");
  lat_two_a: assert property (
    rd && !l3_q && dqm_in == 2'b00 ##1 !cut |-> ##1 dq_oe_out == 2'b11) else $error("latency two late");
  lat_three_a: assert property (
    rd && l3_q ##1 !cut && dqm_in == 2'b00 ##1 !cut |-> ##1 dq_oe_out == 2'b11) else $error("latency three late");
  len_one_a: assert property (
    rd && bl_q == sdb_pkg::BL_1 && !l3_q && dqm_in == 2'b00 ##1 !cut [*2]
    |-> ##1 dq_oe_out == 2'b00 && $past(dq_oe_out) == 2'b11) else $error("length one wrong");
  len_four_a: assert property (
    rd && bl_q == sdb_pkg::BL_4 && !l3_q && dqm_in == 2'b00 ##1 !cut [*5]
    |-> ##1 dq_oe_out == 2'b00 && $past(dq_oe_out, 4) == 2'b11) else $error("length four wrong");
  len_eight_a: assert property (
    rd && bl_q == sdb_pkg::BL_8 && l3_q ##1 !cut [*8] ##1 !cut
    |-> ##2 dq_oe_out == 2'b00 && $past(dq_oe_out, 8) != 2'b00) else $error("length eight wrong");
  page_runs_a: assert property (
    rd && bl_q == sdb_pkg::BL_PAGE && !l3_q ##1 !cut [*8] ##1 !cut
    |-> ##1 dq_oe_out != 2'b00) else $error("page burst stopped");
endmodule
bind sdb_core sdb_core_chk chk (.clk_in(clk_in), .rst_n_in(rst_n_in), .cke_in(cke_in), .cs_n_in(cs_n_in),
  .ras_n_in(ras_n_in), .cas_n_in(cas_n_in), .we_n_in(we_n_in), .addr_in(addr_in), .dqm_in(dqm_in),
  .dq_oe_out(dq_oe_out));

// ### tb/sdb_core_tb.sv
`timescale 1ns/10ps
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin num_errors++; $display("BAD t=%0t got=%h exp=%h", $time, (g), (e)); end end
module sdb_core_tb;
  logic        clk_in = 1'b0;
  logic        rst_n_in = 1'b0;
  logic        cke;
  logic [3:0]  cmd;
  logic [1:0]  ba;
  logic [1:0]  dqm;
  logic [1:0]  dq_oe;
  logic [11:0] addr;
  logic [15:0] dq_w;
  logic [15:0] dq_r;
  logic [15:0] img [512];
  int          num_errors = 0;
  int          checks = 0;
  int          cycles = 0;
  localparam logic [3:0] RD = {1'b0, sdb_pkg::CMD_READ};
  localparam logic [3:0] WR = {1'b0, sdb_pkg::CMD_WRITE};
  always #5 clk_in = ~clk_in;
  sdb_mem_ctrl ctl (.clk_in(clk_in), .cke_out(cke), .cmd_out(cmd), .bank_out(ba), .addr_out(addr),
    .dqm_out(dqm), .dq_wr_out(dq_w));
  sdb_core dut (.clk_in(clk_in), .rst_n_in(rst_n_in), .cke_in(cke), .cs_n_in(cmd[3]), .ras_n_in(cmd[2]),
    .cas_n_in(cmd[1]), .we_n_in(cmd[0]), .bank_select_lo_in(ba[0]), .bank_select_hi_in(ba[1]),
    .addr_in(addr), .dqm_in(dqm), .dq_in(dq_w), .dq_out(dq_r), .dq_oe_out(dq_oe));
  task automatic wrap_up();
    $display("checks=%0d num_errors=%0d", checks, num_errors);
    if (num_errors == 0 && checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic t_fill();
    logic [8:0] c;
    ctl.load(12'h020);
    for (int i = 0; i < 20; i++)
    begin
      c = i < 16 ? 9'(i) : 9'(492 + i);
      img[c] = 16'ha000 | 16'(c);
      ctl.cmd(WR, 2'h0, 12'(c), img[c], 1'b1);
    end
    ctl.nop(3);
  endtask
  // second pass sets the single-write bit: only the first word may land
  task automatic t_wburst();
    logic [8:0] c;
    for (int w = 0; w < 2; w++)
    begin
      ctl.load(w ? 12'h222 : 12'h022);
      for (int k = 0; k < 4; k++)
      begin
        c = w ? 9'h004 : 9'h008 | ((9'h001 + 9'(k)) & 9'h003);
        if (w == 0 || k == 0)
          img[c] = 16'hb000 + 16'(w * 16 + k);
        ctl.cmd(k ? 4'h7 : WR, 2'h0, w ? 12'h004 : 12'h009, 16'hb000 + 16'(w * 16 + k), 1'b1);
      end
      ctl.nop(3);
    end
  endtask
  task automatic rd_chk(input logic [11:0] m, input logic [9:0] c);
    logic [9:0] msk;
    logic [9:0] col;
    int         n;
    msk = m[2:0] == sdb_pkg::BL_PAGE ? 10'h1ff : 10'((1 << m[2:0]) - 1);
    n = msk == 10'h1ff ? 10 : int'(msk) + 1;
    ctl.load(m);
    ctl.cmd(RD, 2'h0, {2'b00, c}, 16'h0000, 1'b0);
    ctl.nop(m[6:4] == sdb_pkg::LAT_3 ? 2 : 1);
    for (int k = 0; k < n; k++)
    begin
      col = (c & ~msk) | ((m[3] ? c ^ 10'(k) : c + 10'(k)) & msk);
      `CHK(dq_r, img[col[8:0]])
      `CHK(dq_oe, 2'b11)
      if (k == n - 1 && n == 10)
        ctl.cmd({1'b0, sdb_pkg::CMD_BST}, 2'h0, 12'h000, 16'h0000, 1'b0);
      else
        ctl.nop(1);
    end
    if (n == 10)
      ctl.nop(4);
    `CHK(dq_oe, 2'b00)
  endtask
  task automatic t_reads();
    logic [11:0] md [9] = '{12'h020, 12'h021, 12'h022, 12'h02a, 12'h022, 12'h022, 12'h033, 12'h03b, 12'h027};
    logic [9:0]  cl [9] = '{10'd3, 10'd5, 10'd1, 10'd1, 10'd9, 10'd4, 10'd13, 10'd10, 10'd510};
    for (int i = 0; i < 9; i++)
      rd_chk(md[i], cl[i]);
  endtask
  // rows opened in banks 3 and 1 must not disturb the bank 0 data from the fill
  task automatic t_banks();
    logic [1:0]  bk [3] = '{2'h3, 2'h1, 2'h0};
    logic [15:0] ex [3] = '{16'hc303, 16'hc103, 16'ha003};
    ctl.load(12'h020);
    for (int i = 0; i < 2; i++)
    begin
      ctl.cmd({1'b0, sdb_pkg::CMD_ACT}, bk[i], 12'h0a0 + 12'(i), 16'h0000, 1'b0);
      ctl.nop(2);
      ctl.cmd(WR, bk[i], 12'h003, ex[i], 1'b1);
      ctl.nop(3);
    end
    for (int i = 0; i < 3; i++)
    begin
      ctl.cmd(RD, bk[i], 12'h003, 16'h0000, 1'b0);
      ctl.nop(1);
      `CHK(dq_r, ex[i])
    end
    ctl.nop(1);
  endtask
  task automatic t_desel();
    ctl.cmd({1'b1, sdb_pkg::CMD_READ}, 2'h0, 12'h001, 16'h0000, 1'b0);
    for (int i = 0; i < 4; i++)
    begin
      ctl.nop(1);
      `CHK(dq_oe, 2'b00)
    end
  endtask
  always @(posedge clk_in)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      num_errors++;
      wrap_up();
    end
  end
  initial
  begin
    repeat (3) @(posedge clk_in);
    @(negedge clk_in);
    rst_n_in = 1'b1;
    `CHK(dq_oe, 2'b00)
    ctl.power_up();
    t_fill();
    t_wburst();
    t_reads();
    t_banks();
    t_desel();
    wrap_up();
  end
endmodule

// ### tb/sdb_mem_ctrl.sv
`timescale 1ns/10ps
module sdb_mem_ctrl #(
  parameter int unsigned WAIT_CYC = 20
) (
  input  wire logic        clk_in,
  output logic             cke_out,
  output logic [3:0]       cmd_out,
  output logic [1:0]       bank_out,
  output logic [11:0]      addr_out,
  output logic [1:0]       dqm_out,
  output logic [15:0]      dq_wr_out
);
  initial
  begin
    cke_out = 1'b1;
    dqm_out = 2'b11;
    cmd_out = 4'hf;
    bank_out = 2'h0;
    addr_out = 12'h000;
    dq_wr_out = 16'h0000;
  end
  // call at a falling edge; a released data bus shows the inverse of its last word
  task automatic cmd(input logic [3:0] c, input logic [1:0] b, input logic [11:0] a, input logic [15:0] d,
                     input bit v);
    cmd_out = c;
    bank_out = b;
    addr_out = a;
    dq_wr_out = v ? d : ~dq_wr_out;
    @(negedge clk_in);
  endtask
  task automatic nop(input int n);
    repeat (n) cmd({1'b0, sdb_pkg::CMD_NOP}, 2'h0, 12'h000, 16'h0000, 1'b0);
  endtask
  task automatic power_up();
    nop(WAIT_CYC);
    cmd({1'b0, sdb_pkg::CMD_PRE}, 2'h0, 12'h400, 16'h0000, 1'b0);
    nop(2);
    repeat (2)
    begin
      cmd({1'b0, sdb_pkg::CMD_REF}, 2'h0, 12'h000, 16'h0000, 1'b0);
      nop(3);
    end
    dqm_out = 2'b00;
  endtask
  // operating-mode and reserved bits forced to zero
  task automatic load(input logic [11:0] m);
    cmd({1'b0, sdb_pkg::CMD_PRE}, 2'h0, 12'h400, 16'h0000, 1'b0);
    nop(2);
    cmd({1'b0, sdb_pkg::CMD_LMR}, 2'h0, m & 12'h27f, 16'h0000, 1'b0);
    nop(2);
    cmd({1'b0, sdb_pkg::CMD_ACT}, 2'h0, 12'h005, 16'h0000, 1'b0);
    nop(2);
  endtask
endmodule
